// [rtl/fcd_ctrl.sv]
// APB controlled host sequencer that issues flash command sequences.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module fcd_ctrl
	import fcd_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Flash pins.
	output logic [21:0] f_addr_o,
	output logic [15:0] f_dq_o,
	output logic f_dq_oe_o,
	input wire logic [15:0] f_dq_i,
	output logic f_ce_n_o,
	output logic f_we_n_o,
	output logic f_oe_n_o
);
	fcd_bus_if bus ();

	typedef enum logic [3:0] {
		FCD_S_IDLE = 4'b0001, FCD_S_ISSUE = 4'b0010, FCD_S_WAIT = 4'b0100,
		FCD_S_END = 4'b1000
	} fcd_st_t;

	fcd_st_t st; // Sequencer state.
	logic [31:0] cmd; // Command register.
	logic [21:0] addr; // Target address register.
	logic [15:0] wdata; // Data register.
	logic [4:0] step; // Index of the cycle within the sequence.
	logic [4:0] nsteps; // Total cycles in the sequence.
	logic busy, done, err; // Status flags.
	logic bypass; // Unlock bypass mode is active.
	logic suspended; // Erase is suspended.
	logic erasing; // A sector erase was issued.
	logic autosel; // Autoselect mode is active.
	logic [15:0] rdata; // Last read word, low byte only unless a plain read.
	logic [21:0] base; // Start address for buffered loads.
	logic cyc_wr; // Direction of the cycle now issued.
	logic [21:0] cyc_addr; // Address of the cycle now issued.
	logic [15:0] cyc_data; // Data of the cycle now issued.
	logic [4:0] wcount; // Buffered word count minus one.

	fcd_op_t op;
	assign op = fcd_op_t'(cmd[CMD_OP_LSB +: 4]);
	assign wcount = {1'b0, cmd[CMD_CNT_LSB +: 4]};

	// A write takes effect only at the access edge where pready is seen high.
	logic apb_wr;
	assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;

	// Sector base: keep A21..A15 and clear the rest.
	function automatic logic [21:0] fcd_sector(input logic [21:0] a);
		fcd_sector = {a[21:SECTOR_LSB], 15'h0};
	endfunction : fcd_sector

	// Cycle count of each operation; buffered load depends on word count.
	function automatic logic [4:0] fcd_len(input fcd_op_t o, input logic [4:0] wc);
		unique case (o)
			FCD_OP_READ, FCD_OP_RESET, FCD_OP_SUSPEND, FCD_OP_RESUME,
			FCD_OP_QUERY: fcd_len = 5'd1;
			FCD_OP_BYP_PROG, FCD_OP_BYP_EXIT, FCD_OP_PEXIT: fcd_len = 5'd2;
			FCD_OP_ABORT, FCD_OP_BYP_ENTER, FCD_OP_PSET: fcd_len = 5'd3;
			FCD_OP_PROG, FCD_OP_AUTOSEL: fcd_len = 5'd4;
			FCD_OP_CERASE, FCD_OP_SERASE: fcd_len = 5'd6;
			FCD_OP_WBUF: fcd_len = 5'(wc + 5'd6);
		endcase
	endfunction : fcd_len

	// Legality check against the tracked device mode.
	function automatic logic fcd_legal(input fcd_op_t o, input logic [4:0] wc);
		unique case (o)
			FCD_OP_BYP_PROG, FCD_OP_BYP_EXIT: fcd_legal = bypass;
			FCD_OP_SUSPEND: fcd_legal = erasing && !suspended;
			FCD_OP_RESUME: fcd_legal = suspended;
			FCD_OP_QUERY: fcd_legal = !bypass && (!erasing || autosel);
			FCD_OP_WBUF: fcd_legal = !bypass && (wc < 5'(BUF_WORDS));
			default: fcd_legal = !bypass || o == FCD_OP_READ || o == FCD_OP_RESET;
		endcase
	endfunction : fcd_legal

	// Address and data of each cycle; unlocks carry only low bits.
	always_comb begin
		cyc_wr = 1'b1;
		cyc_addr = ADDR_UNLOCK1;
		cyc_data = D_AA;
		if (step == 5'd1) begin
			cyc_addr = ADDR_UNLOCK2;
			cyc_data = D_55;
		end
		unique case (op)
			FCD_OP_READ: begin
				// Plain read with no command cycles.
				cyc_wr = 1'b0;
				cyc_addr = addr;
			end
			FCD_OP_RESET: begin
				// Reset leaves autoselect or a timed-out status.
				cyc_addr = addr;
				cyc_data = D_RESET;
			end
			FCD_OP_AUTOSEL: begin
				if (step == 5'd2) begin
					cyc_data = D_AUTOSEL;
				end else if (step == 5'd3) begin
					// Read cycle at the id offset, one word per request.
					cyc_wr = 1'b0;
					cyc_addr = (addr[7:0] == AS_VERIFY[7:0]) ? (fcd_sector(addr) | AS_VERIFY) : addr;
				end
			end
			FCD_OP_PROG, FCD_OP_PSET, FCD_OP_ABORT, FCD_OP_BYP_ENTER: begin
				if (step == 5'd2) begin
					cyc_data = (op == FCD_OP_PROG) ? D_PROG :
						(op == FCD_OP_ABORT) ? D_RESET :
						(op == FCD_OP_BYP_ENTER) ? D_BYPASS : {8'h00, cmd[CMD_ARG_LSB +: 8]};
				end else if (step == 5'd3) begin
					cyc_addr = addr;
					cyc_data = wdata;
				end
			end
			FCD_OP_WBUF: begin
				// Slots stay inside the start page.
				if (step == 5'd2 || step == 5'd3) begin
					cyc_addr = fcd_sector(addr);
					cyc_data = (step == 5'd2) ? D_WBUF : {11'h0, wcount};
				end else if (step == 5'd4 + wcount + 5'd1) begin
					cyc_addr = fcd_sector(addr);
					cyc_data = D_WCONF;
				end else if (step >= 5'd4) begin
					cyc_addr = base | 22'(step - 5'd4);
					cyc_data = wdata;
				end
			end
			FCD_OP_BYP_PROG, FCD_OP_PEXIT, FCD_OP_BYP_EXIT: begin
				// Bypass program, or the 90/00 exits.
				cyc_addr = (step == 5'd0) ? 22'h0 : addr;
				cyc_data = (op == FCD_OP_BYP_PROG) ? ((step == 5'd0) ? D_PROG : wdata) :
					((step == 5'd0) ? D_AUTOSEL : D_ZERO);
			end
			FCD_OP_CERASE, FCD_OP_SERASE: begin
				if (step == 5'd2) cyc_data = D_ERASE;
				else if (step == 5'd4) begin
					// Second unlock pair of the erase sequence.
					cyc_addr = ADDR_UNLOCK2;
					cyc_data = D_55;
				end
				if (step == 5'd5) begin
					cyc_addr = (op == FCD_OP_SERASE) ? fcd_sector(addr) : ADDR_UNLOCK1;
					cyc_data = (op == FCD_OP_SERASE) ? D_SERASE : D_CERASE;
				end
			end
			FCD_OP_SUSPEND, FCD_OP_RESUME: begin
				// Single-write suspend or resume.
				cyc_addr = 22'h0;
				cyc_data = (op == FCD_OP_SUSPEND) ? D_SUSPEND : D_RESUME;
			end
			FCD_OP_QUERY: begin
				cyc_addr = ADDR_QUERY;
				cyc_data = D_QUERY;
			end
		endcase
	end

	// APB register access; a command write starts the sequencer.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cmd <= 32'h0;
			addr <= 22'h0;
			wdata <= 16'h0;
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && paddr_i > REG_RDATA;
			if (apb_wr) begin
				if (paddr_i == REG_CMD && !busy) cmd <= pwdata_i;
				if (paddr_i == REG_ADDR) addr <= pwdata_i[21:0];
				if (paddr_i == REG_DATA) wdata <= pwdata_i[15:0];
			end
			if (psel_i && !penable_i && !pwrite_i) begin
				unique case (paddr_i)
					REG_CMD: prdata_o <= cmd;
					REG_ADDR: prdata_o <= {10'h0, addr};
					REG_DATA: prdata_o <= {16'h0, wdata};
					REG_STATUS: prdata_o <= {24'h0, autosel, suspended, bypass, erasing,
						rdata[0], err, done, busy};
					REG_RDATA: prdata_o <= {16'h0, rdata};
					default: prdata_o <= RDATA_RESET;
				endcase
			end
		end
	end

	// Sequencer: one bus cycle per step, then mode bookkeeping.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st <= FCD_S_IDLE;
			step <= 5'h0;
			nsteps <= 5'h0;
			busy <= 1'b0;
			done <= 1'b0;
			err <= 1'b0;
			bypass <= 1'b0;
			suspended <= 1'b0;
			erasing <= 1'b0;
			autosel <= 1'b0;
			rdata <= 16'h0;
			base <= 22'h0;
			bus.req <= 1'b0;
		end else begin
			bus.req <= 1'b0;
			unique case (st)
				FCD_S_IDLE: begin
					if (apb_wr && paddr_i == REG_CMD && !busy) begin
						done <= 1'b0;
						err <= 1'b0;
						busy <= 1'b1;
						st <= FCD_S_END;
						step <= 5'h0;
					end
				end
				FCD_S_END: begin
					// First cycle after the command latched: check and size it.
					if (!fcd_legal(op, wcount)) begin
						err <= 1'b1;
						busy <= 1'b0;
						done <= 1'b1;
						st <= FCD_S_IDLE;
					end else begin
						nsteps <= fcd_len(op, wcount);
						base <= {addr[21:4], 4'h0};
						st <= FCD_S_ISSUE;
					end
				end
				FCD_S_ISSUE: begin
					bus.req <= 1'b1;
					st <= FCD_S_WAIT;
				end
				FCD_S_WAIT: begin
					if (bus.done) begin
						if (!cyc_wr) rdata <= {8'h00, bus.rdata[7:0]} |
							((op == FCD_OP_READ) ? {bus.rdata[15:8], 8'h00} : 16'h0);
						if (step + 5'd1 == nsteps) begin
							busy <= 1'b0;
							done <= 1'b1;
							st <= FCD_S_IDLE;
							if (op == FCD_OP_BYP_ENTER) bypass <= 1'b1;
							// A plain reset leaves bypass mode in force.
							if (op == FCD_OP_BYP_EXIT) bypass <= 1'b0;
							if (op == FCD_OP_SERASE) erasing <= 1'b1;
							if (op == FCD_OP_SUSPEND) suspended <= 1'b1;
							if (op == FCD_OP_RESUME) suspended <= 1'b0;
							if (op == FCD_OP_AUTOSEL) autosel <= 1'b1;
							if (op == FCD_OP_RESET || op == FCD_OP_ABORT) autosel <= 1'b0;
						end else begin
							step <= step + 5'd1;
							st <= FCD_S_ISSUE;
						end
					end
				end
			endcase
		end
	end

	assign bus.wr = cyc_wr;
	assign bus.addr = cyc_addr;
	assign bus.wdata = cyc_data;

	fcd_cycle u_cycle (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.bus(bus),
		.f_addr_o(f_addr_o),
		.f_dq_o(f_dq_o),
		.f_dq_oe_o(f_dq_oe_o),
		.f_dq_i(f_dq_i),
		.f_ce_n_o(f_ce_n_o),
		.f_we_n_o(f_we_n_o),
		.f_oe_n_o(f_oe_n_o)
	);

	a_buf_len: assert property (@(posedge mclk_i) disable iff (rst_i)
		st == FCD_S_ISSUE && op == FCD_OP_WBUF |-> nsteps <= 5'(MAX_BUF_CYCLES))
		else $error("Buffered sequence too long.");
	a_byp_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		st == FCD_S_ISSUE && op == FCD_OP_BYP_PROG |-> bypass)
		else $error("Bypass program outside bypass mode.");
	a_resume_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		st == FCD_S_ISSUE && op == FCD_OP_RESUME |-> suspended)
		else $error("Resume issued while not suspended.");
	a_suspend_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		st == FCD_S_ISSUE && op == FCD_OP_SUSPEND |-> erasing)
		else $error("Suspend issued with no erase.");
	a_unlock_low: assert property (@(posedge mclk_i) disable iff (rst_i)
		bus.req && step == 5'd1 && op != FCD_OP_WBUF && op >= FCD_OP_AUTOSEL
		&& op != FCD_OP_BYP_PROG && op != FCD_OP_BYP_EXIT && op != FCD_OP_PEXIT
		&& op != FCD_OP_SUSPEND && op != FCD_OP_RESUME && op != FCD_OP_QUERY
		|-> bus.addr == ADDR_UNLOCK2)
		else $error("Second unlock address wrong.");
	a_exit_pair: assert property (@(posedge mclk_i) disable iff (rst_i)
		bus.req && op == FCD_OP_PEXIT && step == 5'd1 |-> bus.wdata == D_ZERO)
		else $error("Exit sequence second word wrong.");
	a_sector_cfm: assert property (@(posedge mclk_i) disable iff (rst_i)
		bus.req && op == FCD_OP_SERASE && step == 5'd5 |-> bus.addr[14:0] == 15'h0)
		else $error("Sector address has low bits set.");
	a_query_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		st == FCD_S_ISSUE && op == FCD_OP_QUERY |-> !bypass)
		else $error("Query issued in bypass mode.");
	c_wbuf: cover property (@(posedge mclk_i) done && op == FCD_OP_WBUF && !err);
	c_bypass: cover property (@(posedge mclk_i) done && op == FCD_OP_BYP_PROG);
	c_suspend: cover property (@(posedge mclk_i) $rose(suspended));
endmodule : fcd_ctrl

// [rtl/fcd_pkg.sv]
// Package with the constants, commands and types of the flash command controller.
// Behaviour
// - Reset command leaves autoselect or timeout status
// - Identifier fetched as three separate reads
// - Buffer slots stay within the start page
// - Load count equals words minus one
// - Buffer sequence at most 21 cycles
// - Bypass program only after bypass entry
// - Bypass left only by bypass reset
// - Protection set entry: AA, 55, set code
// - Protection set exit: 90 then 00
// - Persistent lock: A0 then 00 in sector (no operation of the controller issues it)
// - Suspend is one B0 write during erase
// - Host sends correct order; reset recovers
package fcd_pkg;
	// Register offsets of the controller's own APB registers.
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	// Field positions in the command register.
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_ARG_LSB = 8;
	localparam int CMD_CNT_LSB = 16;
	// Field positions in the status register.
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam int ST_PROT_BIT = 3;
	// Reset value of the read data register.
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	// Unlock addresses and codes.
	localparam logic [21:0] ADDR_UNLOCK1 = 22'h000555;
	localparam logic [21:0] ADDR_UNLOCK2 = 22'h0002aa;
	localparam logic [21:0] ADDR_QUERY = 22'h000055;
	localparam logic [15:0] D_AA = 16'h00aa;
	localparam logic [15:0] D_55 = 16'h0055;
	localparam logic [15:0] D_RESET = 16'h00f0;
	localparam logic [15:0] D_AUTOSEL = 16'h0090;
	localparam logic [15:0] D_PROG = 16'h00a0;
	localparam logic [15:0] D_WBUF = 16'h0025;
	localparam logic [15:0] D_WCONF = 16'h0029;
	localparam logic [15:0] D_BYPASS = 16'h0020;
	localparam logic [15:0] D_ERASE = 16'h0080;
	localparam logic [15:0] D_SERASE = 16'h0030;
	localparam logic [15:0] D_CERASE = 16'h0010;
	localparam logic [15:0] D_SUSPEND = 16'h00b0;
	localparam logic [15:0] D_RESUME = 16'h0030;
	localparam logic [15:0] D_QUERY = 16'h0098;
	localparam logic [15:0] D_ZERO = 16'h0000;
	// Autoselect word offsets.
	localparam logic [21:0] AS_MAKER = 22'h000000;
	localparam logic [21:0] AS_DEV1 = 22'h000001;
	localparam logic [21:0] AS_VERIFY = 22'h000002;
	localparam logic [21:0] AS_DEV2 = 22'h00000e;
	localparam logic [21:0] AS_DEV3 = 22'h00000f;
	// Sector field and write buffer limits.
	localparam int SECTOR_LSB = 15;
	localparam int MAX_BUF_CYCLES = 21;
	localparam int BUF_WORDS = 16;
	// Bus strobe timing in clock cycles.
	localparam int T_SETUP = 2;
	localparam int T_PULSE = 3;
	localparam int T_HOLD = 2;
	// Host operations.
	typedef enum logic [3:0] {
		FCD_OP_READ = 4'h0, FCD_OP_RESET = 4'h1, FCD_OP_AUTOSEL = 4'h2,
		FCD_OP_PROG = 4'h3, FCD_OP_WBUF = 4'h4, FCD_OP_ABORT = 4'h5,
		FCD_OP_BYP_ENTER = 4'h6, FCD_OP_BYP_PROG = 4'h7, FCD_OP_BYP_EXIT = 4'h8,
		FCD_OP_CERASE = 4'h9, FCD_OP_SERASE = 4'ha, FCD_OP_SUSPEND = 4'hb,
		FCD_OP_RESUME = 4'hc, FCD_OP_QUERY = 4'hd, FCD_OP_PSET = 4'he,
		FCD_OP_PEXIT = 4'hf
	} fcd_op_t;
endpackage : fcd_pkg

// [rtl/fcd_bus_if.sv]
// Interface between the sequencer and the flash bus cycle engine.
`timescale 1ns/1ps
interface fcd_bus_if;
	logic req; // Start one bus cycle.
	logic wr; // One for a write cycle.
	logic [21:0] addr; // Word address.
	logic [15:0] wdata; // Write data.
	logic done; // Pulse when the cycle ends.
	logic [15:0] rdata; // Read data on done.
	modport seq (output req, wr, addr, wdata, input done, rdata);
	modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface : fcd_bus_if

// [rtl/fcd_cycle.sv]
// Flash bus cycle engine: one asynchronous read or write per request.
`timescale 1ns/1ps
module fcd_cycle
	import fcd_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Sequencer side.
	fcd_bus_if.eng bus,
	// Flash pins.
	output logic [21:0] f_addr_o,
	output logic [15:0] f_dq_o,
	output logic f_dq_oe_o,
	input wire logic [15:0] f_dq_i,
	output logic f_ce_n_o,
	output logic f_we_n_o,
	output logic f_oe_n_o
);
	typedef enum logic [3:0] {
		FCD_C_IDLE = 4'b0001, FCD_C_SETUP = 4'b0010, FCD_C_PULSE = 4'b0100,
		FCD_C_HOLD = 4'b1000
	} fcd_cst_t;
	fcd_cst_t cst; // Cycle phase.
	logic [3:0] cnt; // Phase timer.
	logic wr_q; // Direction of the running cycle.

	// Phase sequencing; write data latches at the rising we edge, which leads ce.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cst <= FCD_C_IDLE;
			cnt <= 4'h0;
			wr_q <= 1'b0;
			f_addr_o <= 22'h0;
			f_dq_o <= 16'h0;
			f_dq_oe_o <= 1'b0;
			f_ce_n_o <= 1'b1;
			f_we_n_o <= 1'b1;
			f_oe_n_o <= 1'b1;
			bus.done <= 1'b0;
			bus.rdata <= 16'h0;
		end else begin
			bus.done <= 1'b0;
			unique case (cst)
				FCD_C_IDLE: begin
					if (bus.req) begin
						f_addr_o <= bus.addr;
						f_dq_o <= bus.wdata;
						f_dq_oe_o <= bus.wr;
						wr_q <= bus.wr;
						f_ce_n_o <= 1'b0;
						cnt <= 4'(T_SETUP);
						cst <= FCD_C_SETUP;
					end
				end
				FCD_C_SETUP: begin
					cnt <= cnt - 4'h1;
					if (cnt == 4'h1) begin
						f_we_n_o <= ~wr_q;
						f_oe_n_o <= wr_q;
						cnt <= 4'(T_PULSE);
						cst <= FCD_C_PULSE;
					end
				end
				FCD_C_PULSE: begin
					cnt <= cnt - 4'h1;
					if (cnt == 4'h1) begin
						// We rises first so the device latches on it.
						f_we_n_o <= 1'b1;
						f_oe_n_o <= 1'b1;
						bus.rdata <= f_dq_i;
						cnt <= 4'(T_HOLD);
						cst <= FCD_C_HOLD;
					end
				end
				FCD_C_HOLD: begin
					f_ce_n_o <= 1'b1;
					cnt <= cnt - 4'h1;
					if (cnt == 4'h1) begin
						f_dq_oe_o <= 1'b0;
						bus.done <= 1'b1;
						cst <= FCD_C_IDLE;
					end
				end
			endcase
		end
	end

	// Write enable must rise while chip select is still low.
	a_we_before_ce: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(f_ce_n_o) |-> $past(f_we_n_o))
		else $error("Chip select rose before write enable.");
endmodule : fcd_cycle

// [verif/fcd_flash_model.sv]
// Behavioural flash device that answers the controller's bus cycles.
`timescale 1ns/1ps
module fcd_flash_model #(
	parameter logic [15:0] MAKER_ID = 16'ha55a, // Arbitrary identity value.
	parameter logic [6:0] PROT_SECTOR = 7'h05 // Sector that reads as protected.
) (
	// Flash pins seen from the device.
	input wire logic [21:0] addr_i,
	input wire logic [15:0] dq_i,
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	output logic [15:0] dq_o
);
	logic [15:0] mem [int]; // Array words written so far.
	logic [15:0] rd = 16'h0; // Word shown during a read.
	logic [7:0] d; // Low data byte of a write.
	logic [7:0] code = 8'h0; // Protection set code last entered.
	logic [1:0] step = 2'h0; // Unlock cycles matched.
	logic [1:0] wb = 2'h0; // Buffer load phase.
	int wn = 0; // Buffer words still expected.
	int wtot = 0; // Buffer words taken.
	logic asel, byp, prot, susp, erasing, er, pend, ex, qry; // Mode flags.
	initial {asel, byp, prot, susp, erasing, er, pend, ex, qry} = '0;
	// Each write is taken at the rising write strobe, while selected.
	always @(posedge we_n_i) begin
		if (ce_n_i === 1'b0) begin
			d = dq_i[7:0];
			if (pend) begin
				mem[int'(addr_i)] = dq_i;
				pend = 1'b0;
			end else if (wb == 2'h1) begin
				wn = int'(dq_i) + 1;
				wtot = 0;
				wb = 2'h2;
			end else if (wb == 2'h2 && wn > 0) begin
				mem[int'(addr_i)] = dq_i;
				wn--;
				wtot++;
			end else if (wb == 2'h2) begin
				wb = 2'h0;
			end else if (ex && d == 8'h00) begin
				{byp, prot, ex} = 3'h0;
			end else if ((byp || prot) && d == 8'h90) begin
				ex = 1'b1;
			end else if (byp && d == 8'ha0) begin
				pend = 1'b1;
			end else if (byp || prot) begin
				ex = 1'b0;
			end else if (step == 2'h0 && d == 8'hf0) begin
				{asel, qry, er} = 3'h0;
			end else if (d == 8'hb0 && erasing) begin
				susp = 1'b1;
			end else if (d == 8'h30 && susp && step == 2'h0) begin
				susp = 1'b0;
			end else if (d == 8'h98 && addr_i[10:0] == 11'h055 && !erasing) begin
				qry = 1'b1;
			end else if (step == 2'h0 && addr_i[10:0] == 11'h555 && d == 8'haa) begin
				step = 2'h1;
			end else if (step == 2'h1 && addr_i[10:0] == 11'h2aa && d == 8'h55) begin
				step = 2'h2;
			end else if (step == 2'h2 && er) begin
				erasing = erasing || d == 8'h30;
				{step, er} = 3'h0;
			end else if (step == 2'h2 && d == 8'h25) begin
				wb = 2'h1;
				step = 2'h0;
			end else if (step == 2'h2 && addr_i[10:0] == 11'h555) begin
				step = 2'h0;
				case (d)
					8'h90: asel = 1'b1;
					8'h20: byp = 1'b1;
					8'ha0: pend = 1'b1;
					8'h80: er = 1'b1;
					8'hf0: wb = 2'h0;
					8'h40, 8'h60, 8'hc0, 8'h50, 8'he0: begin
						prot = 1'b1;
						code = d;
					end
					default: ;
				endcase
			end else begin
				step = 2'h0;
			end
		end
	end
	// A read word is chosen when the output strobe falls.
	always @(negedge oe_n_i) begin
		if (asel && addr_i[7:0] == 8'h00) rd = MAKER_ID;
		else if (asel) rd = {8'hc3, 7'h0, addr_i[21:15] == PROT_SECTOR};
		else rd = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 16'hffff;
	end
	// A released bus shows the inverse word, so no stale value passes.
	assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
endmodule : fcd_flash_model

// [verif/tb.sv]
// Self-checking testbench for the APB flash command controller.
`timescale 1ns/1ps
module tb;
	import fcd_pkg::*;
	localparam logic [15:0] MAKER = 16'ha55a; // Arbitrary identity value.
	localparam logic [6:0] PSEC = 7'h05; // Protected sector in the model.
	logic mclk_i, rst_i, psel, penable, pwrite, pready, pslverr, rerr; // Bus controls.
	logic [7:0] paddr; // APB address.
	logic [31:0] pwdata, prdata, r; // APB data and last read.
	logic [21:0] f_addr, a; // Flash address and scenario address.
	logic [15:0] f_dq, f_in, dev_dq, v; // Flash data lines and scenario word.
	logic f_oe, f_ce_n, f_we_n, f_oe_n; // Flash strobes.
	logic [31:0] exp_q [$], msk_q [$]; // Expected reads and their masks.
	logic [15:0] lfsr = 16'h0043; // Random source.
	logic [7:0] codes [5] = '{8'h40, 8'h60, 8'hc0, 8'h50, 8'he0}; // Set codes.
	int err_count = 0, total_checks = 0, n;
	fcd_ctrl uut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .f_addr_o(f_addr), .f_dq_o(f_dq),
		.f_dq_oe_o(f_oe), .f_dq_i(f_in), .f_ce_n_o(f_ce_n), .f_we_n_o(f_we_n),
		.f_oe_n_o(f_oe_n));
	fcd_flash_model #(.MAKER_ID(MAKER), .PROT_SECTOR(PSEC)) m (.addr_i(f_addr),
		.dq_i(f_in), .ce_n_i(f_ce_n), .we_n_i(f_we_n), .oe_n_i(f_oe_n), .dq_o(dev_dq));
	// The shared data wire follows whichever side drives it.
	assign f_in = f_oe ? f_dq : dev_dq;
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer, held until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		@(posedge mclk_i);
		while (pready !== 1'b1) @(posedge mclk_i);
		r = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_i);
	endtask : apb
	// A read whose result the monitor compares.
	task automatic rdx(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk);
		exp_q.push_back(e);
		msk_q.push_back(mk);
		apb(1'b0, ad, 32'h0);
	endtask : rdx
	// Loads address and data, issues an operation and waits while busy.
	task automatic cmd(input fcd_op_t op, input logic [7:0] arg, input logic [3:0] cnt,
		input logic [21:0] ad, input logic [15:0] d);
		apb(1'b1, REG_ADDR, {10'h0, ad});
		apb(1'b1, REG_DATA, {16'h0, d});
		apb(1'b1, REG_CMD, {12'h0, cnt, arg, 4'h0, op});
		r = 32'h1;
		for (n = 0; n < 300 && r[ST_BUSY_BIT] !== 1'b0; n++) apb(1'b0, REG_STATUS, 32'h0);
		chk(32'(r[ST_BUSY_BIT]), 32'h0);
	endtask : cmd
	// The monitor compares each checked read as it completes.
	always @(posedge mclk_i) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			chk(prdata & msk_q.pop_front(), exp_q.pop_front());
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// Watchdog for a hung handshake.
	initial begin
		repeat (80000) @(posedge mclk_i);
		err_count++;
		stop_test();
	end
	initial begin
		{psel, penable, pwrite, rst_i} = 4'h1;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		rdx(REG_STATUS, 32'h0, 32'hff);
		rdx(REG_RDATA, RDATA_RESET, '1);
		apb(1'b0, 8'h14, 32'h0);
		chk(32'(rerr), 32'h1);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			lfsr = nxt(lfsr);
			a = {6'h02, lfsr};
			lfsr = nxt(lfsr);
			cmd(FCD_OP_PROG, 8'h0, 4'h0, a, lfsr);
			cmd(FCD_OP_READ, 8'h0, 4'h0, a, 16'h0);
			rdx(REG_RDATA, {16'h0, lfsr}, 32'hffff);
		end
		cmd(FCD_OP_READ, 8'h0, 4'h0, 22'h3f0000, 16'h0);
		rdx(REG_RDATA, 32'hffff, 32'hffff);
		$display("test program done");
		cmd(FCD_OP_AUTOSEL, 8'h0, 4'h0, AS_MAKER, 16'h0);
		rdx(REG_RDATA, {24'h0, MAKER[7:0]}, '1);
		rdx(REG_STATUS, 32'h80, 32'h80);
		cmd(FCD_OP_AUTOSEL, 8'h0, 4'h0, {PSEC, 15'h0002}, 16'h0);
		rdx(REG_RDATA, 32'h1, '1);
		cmd(FCD_OP_AUTOSEL, 8'h0, 4'h0, {7'h06, 15'h0002}, 16'h0);
		rdx(REG_RDATA, 32'h0, '1);
		cmd(FCD_OP_RESET, 8'h0, 4'h0, 22'h0, 16'h0);
		chk(32'(m.asel), 32'h0);
		$display("test autoselect done");
		lfsr = nxt(lfsr);
		v = lfsr;
		cmd(FCD_OP_BYP_PROG, 8'h0, 4'h0, 22'h001234, v);
		cmd(FCD_OP_READ, 8'h0, 4'h0, 22'h001234, 16'h0);
		rdx(REG_RDATA, 32'hffff, 32'hffff);
		cmd(FCD_OP_BYP_ENTER, 8'h0, 4'h0, 22'h0, 16'h0);
		rdx(REG_STATUS, 32'h20, 32'h20);
		cmd(FCD_OP_BYP_PROG, 8'h0, 4'h0, 22'h001234, v);
		cmd(FCD_OP_RESET, 8'h0, 4'h0, 22'h0, 16'h0);
		rdx(REG_STATUS, 32'h20, 32'h20);
		chk(32'(m.byp), 32'h1);
		cmd(FCD_OP_BYP_EXIT, 8'h0, 4'h0, 22'h0, 16'h0);
		chk(32'(m.byp), 32'h0);
		cmd(FCD_OP_READ, 8'h0, 4'h0, 22'h001234, 16'h0);
		rdx(REG_RDATA, {16'h0, v}, 32'hffff);
		$display("test bypass done");
		cmd(FCD_OP_QUERY, 8'h0, 4'h0, ADDR_QUERY, 16'h0);
		chk(32'(m.qry), 32'h1);
		cmd(FCD_OP_RESET, 8'h0, 4'h0, 22'h0, 16'h0);
		cmd(FCD_OP_WBUF, 8'h0, 4'hf, 22'h010040, v);
		chk(32'(m.wtot), 32'd16);
		cmd(FCD_OP_READ, 8'h0, 4'h0, 22'h01004f, 16'h0);
		rdx(REG_RDATA, {16'h0, v}, 32'hffff);
		cmd(FCD_OP_ABORT, 8'h0, 4'h0, 22'h0, 16'h0);
		chk(32'({m.wb, m.step}), 32'h0);
		$display("test buffer done");
		foreach (codes[i]) begin
			cmd(FCD_OP_PSET, codes[i], 4'h0, 22'h0, 16'h0);
			chk({23'h0, m.prot, m.code}, {24'h1, codes[i]});
			cmd(FCD_OP_PEXIT, 8'h0, 4'h0, 22'h0, 16'h0);
			chk(32'(m.prot), 32'h0);
		end
		$display("test protection done");
		cmd(FCD_OP_CERASE, 8'h0, 4'h0, 22'h0, 16'h0);
		cmd(FCD_OP_SUSPEND, 8'h0, 4'h0, 22'h0, 16'h0);
		chk(32'(m.susp), 32'h0);
		cmd(FCD_OP_SERASE, 8'h0, 4'h0, 22'h0a0000, 16'h0);
		cmd(FCD_OP_SUSPEND, 8'h0, 4'h0, 22'h0, 16'h0);
		chk(32'(m.susp), 32'h1);
		rdx(REG_STATUS, 32'h50, 32'h50);
		cmd(FCD_OP_PROG, 8'h0, 4'h0, 22'h0c0010, v);
		cmd(FCD_OP_READ, 8'h0, 4'h0, 22'h0c0010, 16'h0);
		rdx(REG_RDATA, {16'h0, v}, 32'hffff);
		cmd(FCD_OP_RESUME, 8'h0, 4'h0, 22'h0, 16'h0);
		chk(32'(m.susp), 32'h0);
		cmd(FCD_OP_RESUME, 8'h0, 4'h0, 22'h0, 16'h0);
		rdx(REG_STATUS, 32'h0, 32'h40);
		$display("test suspend done");
		stop_test();
	end
endmodule : tb
